/* File: hdl/i2cms_pkg.sv */
package i2cms_pkg;

    // Register offsets
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL  = 8'h0B;
    localparam logic [7:0] ADDR_PERIPH_FLAGS_ONE   = 8'h0C;
    localparam logic [7:0] ADDR_PERIPH_FLAGS_TWO   = 8'h0D;
    localparam logic [7:0] ADDR_SHIFT_BUFFER       = 8'h13;
    localparam logic [7:0] ADDR_CONTROL_ONE        = 8'h14;
    localparam logic [7:0] ADDR_PERIPH_ENABLES_ONE = 8'h8C;
    localparam logic [7:0] ADDR_PERIPH_ENABLES_TWO = 8'h8D;
    localparam logic [7:0] ADDR_CONTROL_TWO        = 8'h91;
    localparam logic [7:0] ADDR_BAUD_RELOAD        = 8'h93;
    localparam logic [7:0] ADDR_STATUS             = 8'h94;

    // Field positions
    localparam int BIT_BEGIN_REQUEST  = 0;  // control two
    localparam int BIT_START_SEEN     = 3;  // status
    localparam int BIT_SLEW_CONTROL   = 7;  // status
    localparam int BIT_PORT_IRQ       = 3;  // flags one
    localparam int BIT_BUS_COLLISION  = 3;  // flags two
    localparam int BIT_WRITE_COLL     = 7;  // control one
    localparam int SEQ_REQ_BITS       = 5;  // low request bits of control two

    // Writable masks of flag and enable registers
    localparam logic [7:0] MASK_FLAGS_ONE   = 8'h4F;
    localparam logic [7:0] MASK_FLAGS_TWO   = 8'h89;
    localparam logic [7:0] MASK_ENABLES_ONE = 8'h4F;
    localparam logic [7:0] MASK_ENABLES_TWO = 8'h89;

    // Reset values
    localparam logic [7:0] RST_REG     = 8'h00;
    localparam logic [6:0] RST_RELOAD  = 7'h00;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } i2cms_bus_t;

    // Sampled two-wire lines
    typedef struct packed {
        logic scl;
        logic sda;
    } i2cms_lines_t;

endpackage

/* File: hdl/i2cms_baud_gen.sv */
`timescale 1ns/1ps
// Baud rate generator: down-counter with reload
module i2cms_baud_gen
    import i2cms_pkg::*;
#(
    parameter int WIDTH = 7
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] reload,
    output logic                  expire
);

    logic [WIDTH-1:0] count_q;
    logic             active_q;

    initial
    begin
        if (WIDTH < 1 || WIDTH > 16)
            $error("baud generator width out of range");
    end

    // Count toward zero from reload value
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            count_q  <= '0;
            active_q <= 1'b0;
        end
        else if (load)
        begin
            count_q  <= reload;                                   // R15
            active_q <= 1'b1;
        end
        else if (!run)
            active_q <= 1'b0;
        else if (active_q && count_q != '0)
            count_q <= count_q - 1'b1;                            // R15
        else if (active_q)
            active_q <= 1'b0;
    end

    assign expire = active_q && run && !load && (count_q == '0); // R15

endmodule

/* File: hdl/i2cms_line_mon.sv */
`timescale 1ns/1ps
// Line monitor: start edge detection on sampled lines
module i2cms_line_mon
    import i2cms_pkg::*;
(
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire i2cms_lines_t lines,
    output logic              start_edge,
    output logic              both_high,
    output logic              both_low
);

    i2cms_lines_t prev_q;

    // Previous sample of both lines
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            prev_q <= '{scl: 1'b1, sda: 1'b1};
        else
            prev_q <= lines;
    end

    // SDA falling while SCL high
    assign start_edge = prev_q.sda && !lines.sda && prev_q.scl && lines.scl;
    assign both_high  = lines.scl && lines.sda;
    assign both_low   = !lines.scl && !lines.sda;

endmodule

/* File: hdl/i2cms_start_gen.sv */
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
// Functional notes
// R1: Software starts a START by setting the begin request bit.
// R2: With request and both lines high, the baud generator loads and counts.
// R3: Lines still high at first expiry: SDA is driven low, SCL left high.
// R4: SDA falling while SCL high sets the start-seen status bit.
// R5: Once start-seen is set, the baud generator reloads for a second period.
// R6: Second expiry completes START and hardware clears the request bit.
// R7: At completion the baud generator stops and SDA stays driven low.
// R8: At completion the port interrupt flag is set.
// R9: Both lines low at request time is a bus collision.
// R10: SCL low before SDA is driven low during START is a bus collision.
// R11: A bus collision sets its flag, aborts START and returns to idle.
// R12: Buffer write during START sets write collision and keeps the buffer.
// R13: Low five request bits of control two ignore writes until START ends.
// R14: The slew control bit selects slew limiting on the bus pins.
// R15: The baud generator counts down from reload to zero, then expires.
module i2cms_start_gen
    import i2cms_pkg::*;
#(
    parameter int RELOAD_W = 7
)
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe_n,
    output logic            sda_out,
    output logic            sda_oe_n,
    output logic            slew_limit
);

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_FIRST = 5'b00010,
        ST_EDGE  = 5'b00100,
        ST_HOLD  = 5'b01000,
        ST_DONE  = 5'b10000
    } i2cms_state_t;

    initial
    begin
        if (RELOAD_W != 7)
            $error("reload field width must be 7");
        if (SEQ_REQ_BITS < 1 || SEQ_REQ_BITS > 7)
            $error("request field does not fit control two");
    end

    i2cms_state_t state_q;
    i2cms_bus_t   bus;
    i2cms_lines_t lines;

    // Register storage
    logic [7:0] interrupt_control_q;
    logic [7:0] flags_one_q;
    logic [7:0] flags_two_q;
    logic [7:0] enables_one_q;
    logic [7:0] enables_two_q;
    logic [7:0] shift_buf_q;
    logic [7:0] control_one_q;
    logic [7:0] control_two_q;
    logic [7:0] reload_q;
    logic [7:0] status_q;
    logic [7:0] rdata_d;
    logic       sda_low_q;

    // Sequencer and timer handshakes
    logic       bg_load;
    logic       bg_run;
    logic       bg_expire;
    logic       start_edge;
    logic       both_high;
    logic       both_low;
    logic       in_start;
    logic       collide;
    logic       complete;
    logic       req_set;
    logic       abort;

    // Register request and sampled lines as structs
    assign bus   = '{addr: reg_addr, wdata: reg_wdata,
                     wr: reg_wr, rd: reg_rd};
    assign lines = '{scl: scl_in, sda: sda_in};

    // Write strobe aimed at one register address
    function automatic logic wr_hit(input i2cms_bus_t b,
                                    input logic [7:0] a);
        return b.wr && (b.addr == a);
    endfunction

    // Start edge and bus-free detection
    i2cms_line_mon u_mon (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .lines      (lines),
        .start_edge (start_edge),
        .both_high  (both_high),
        .both_low   (both_low)
    );

    // Baud period timer
    i2cms_baud_gen #(.WIDTH(RELOAD_W)) u_baud (
        .clk_sys (clk_sys),
        .rst     (rst),
        .load    (bg_load),
        .run     (bg_run),
        .reload  (reload_q[RELOAD_W-1:0]),
        .expire  (bg_expire)
    );

    // Sequence decode
    assign req_set  = control_two_q[BIT_BEGIN_REQUEST];                // R1
    assign in_start = (state_q != ST_IDLE) && (state_q != ST_DONE);
    assign collide  = (state_q == ST_IDLE && req_set && both_low)      // R9
                   || ((state_q == ST_FIRST) && !lines.scl);           // R10
    assign complete = (state_q == ST_HOLD) && bg_expire;
    assign bg_load  = (state_q == ST_IDLE && req_set && both_high)     // R2
                   || (state_q == ST_EDGE && status_q[BIT_START_SEEN]); // R5
    assign bg_run   = (state_q == ST_FIRST) || (state_q == ST_HOLD);   // R7

    // First period ended with SDA held low by another party: give up
    assign abort    = (state_q == ST_FIRST) && bg_expire && !both_high
                   && !collide;

    // START sequencer
    // IDLE waits for a free bus, DONE keeps SDA low until a new request
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            state_q <= ST_IDLE;
        else
        begin
            unique case (state_q)
                ST_IDLE:
                    if (collide)
                        state_q <= ST_IDLE;                            // R11
                    else if (bg_load)
                        state_q <= ST_FIRST;                           // R2
                ST_FIRST:
                    if (collide)
                        state_q <= ST_IDLE;                            // R11
                    else if (bg_expire && both_high)
                        state_q <= ST_EDGE;                            // R3
                    else if (bg_expire)
                    begin
                        state_q <= ST_IDLE;                            // R11
                    end
                ST_EDGE:
                    if (status_q[BIT_START_SEEN])
                        state_q <= ST_HOLD;                            // R5
                ST_HOLD:
                    if (complete)
                        state_q <= ST_DONE;                            // R6
                ST_DONE:
                    if (req_set)
                        state_q <= ST_IDLE;
            endcase
        end
    end

    // SDA drive: held low from first expiry until next request
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            sda_low_q <= 1'b0;
        else if (state_q == ST_FIRST && bg_expire && both_high)
            sda_low_q <= 1'b1;                                         // R3
        else if (collide)
            sda_low_q <= 1'b0;                                         // R11
        else if (state_q == ST_DONE && req_set)
            sda_low_q <= 1'b0;
    end

    // Pin drivers, output enable low while driving
    // SCL is never driven: this block only forms the START
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sda_out  <= 1'b1;
            sda_oe_n <= 1'b1;
            scl_out  <= 1'b1;
            scl_oe_n <= 1'b1;
        end
        else
        begin
            sda_out  <= 1'b0;
            sda_oe_n <= !sda_low_q;                                    // R7
            scl_out  <= 1'b1;
            scl_oe_n <= 1'b1;                                          // R3
        end
    end

    // Slew limiting follows status bit (0 = limited)
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            slew_limit <= 1'b1;
        else
            slew_limit <= !status_q[BIT_SLEW_CONTROL];                 // R14
    end

    // Status register: slew bit writable, start-seen set by hardware
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            status_q <= RST_REG;
        else
        begin
            if (wr_hit(bus, ADDR_STATUS))
                status_q[BIT_SLEW_CONTROL] <= bus.wdata[BIT_SLEW_CONTROL];
            if (start_edge)
                status_q[BIT_START_SEEN] <= 1'b1;                      // R4
            else if (state_q == ST_IDLE && bg_load)
                status_q[BIT_START_SEEN] <= 1'b0;
        end
    end

    // Control two: request bits locked during START
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            control_two_q <= RST_REG;
        else
        begin
            if (wr_hit(bus, ADDR_CONTROL_TWO))
            begin
                control_two_q[7:SEQ_REQ_BITS] <= bus.wdata[7:SEQ_REQ_BITS];
                if (!in_start && !complete)
                    control_two_q[SEQ_REQ_BITS-1:0] <=
                        bus.wdata[SEQ_REQ_BITS-1:0];                   // R13
            end
            if (complete || collide || abort)
                control_two_q[BIT_BEGIN_REQUEST] <= 1'b0;              // R6
        end
    end

    // Buffer and control one, write collision during START
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            shift_buf_q   <= RST_REG;
            control_one_q <= RST_REG;
        end
        else
        begin
            if (wr_hit(bus, ADDR_CONTROL_ONE))
                control_one_q <= bus.wdata;
            if (wr_hit(bus, ADDR_SHIFT_BUFFER))
            begin
                if (in_start)
                    control_one_q[BIT_WRITE_COLL] <= 1'b1;             // R12
                else
                    shift_buf_q <= bus.wdata;                          // R12
            end
        end
    end

    // Flag registers: hardware set wins over software clear
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            flags_one_q <= RST_REG;
            flags_two_q <= RST_REG;
        end
        else
        begin
            if (wr_hit(bus, ADDR_PERIPH_FLAGS_ONE))
                flags_one_q <= bus.wdata & MASK_FLAGS_ONE;
            if (wr_hit(bus, ADDR_PERIPH_FLAGS_TWO))
                flags_two_q <= bus.wdata & MASK_FLAGS_TWO;
            if (complete)
                flags_one_q[BIT_PORT_IRQ] <= 1'b1;                     // R8
            if (collide)
                flags_two_q[BIT_BUS_COLLISION] <= 1'b1;                // R11
        end
    end

    // Plain storage registers
    // Reload keeps all eight bits; the timer uses the low seven
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            interrupt_control_q      <= RST_REG;
            enables_one_q <= RST_REG;
            enables_two_q <= RST_REG;
            reload_q      <= RST_REG;
        end
        else if (bus.wr)
        begin
            unique case (bus.addr)
                ADDR_INTERRUPT_CONTROL:  interrupt_control_q      <= bus.wdata;
                ADDR_PERIPH_ENABLES_ONE:
                    enables_one_q <= bus.wdata & MASK_ENABLES_ONE;
                ADDR_PERIPH_ENABLES_TWO:
                    enables_two_q <= bus.wdata & MASK_ENABLES_TWO;
                ADDR_BAUD_RELOAD:        reload_q      <= bus.wdata;
                default:                 ;
            endcase
        end
    end

    // Read mux
    // Unmapped addresses read as zero
    always_comb
    begin
        unique case (bus.addr)
            ADDR_INTERRUPT_CONTROL:  rdata_d = interrupt_control_q;
            ADDR_PERIPH_FLAGS_ONE:   rdata_d = flags_one_q;
            ADDR_PERIPH_FLAGS_TWO:   rdata_d = flags_two_q;
            ADDR_SHIFT_BUFFER:       rdata_d = shift_buf_q;
            ADDR_CONTROL_ONE:        rdata_d = control_one_q;
            ADDR_PERIPH_ENABLES_ONE: rdata_d = enables_one_q;
            ADDR_PERIPH_ENABLES_TWO: rdata_d = enables_two_q;
            ADDR_CONTROL_TWO:        rdata_d = control_two_q;
            ADDR_BAUD_RELOAD:        rdata_d = reload_q;
            ADDR_STATUS:             rdata_d = status_q;
            default:                 rdata_d = 8'h00;
        endcase
    end

    // Read data one cycle after strobe
    // Read data returns to zero outside a read
    always_ff @(posedge clk_sys)
    begin
        if (rst)
            reg_rdata <= RST_REG;
        else if (bus.rd)
            reg_rdata <= rdata_d;
        else
            reg_rdata <= 8'h00;
    end

endmodule

/* File: test/i2cms_bus_model.sv */
`timescale 1ns/1ps
// Other parties on the two-wire bus, pull-ups on both lines
module i2cms_bus_model
(
    input  wire logic scl_out,
    input  wire logic scl_oe_n,
    input  wire logic sda_out,
    input  wire logic sda_oe_n,
    input  wire logic hold_scl,
    input  wire logic hold_sda,
    output logic      scl_in,
    output logic      sda_in
);
    // Wired-AND: low when any party pulls, else pulled high
    assign scl_in = ~hold_scl & (scl_oe_n | scl_out);
    assign sda_in = ~hold_sda & (sda_oe_n | sda_out);
endmodule

/* File: test/i2cms_start_chk.sv */
`timescale 1ns/1ps
// Port-level checks of the start generator
module i2cms_start_chk
    import i2cms_pkg::*;
#(
    parameter int RELOAD_W = 7
)
(
    input wire logic       clk_sys,
    input wire logic       rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       scl_out,
    input wire logic       scl_oe_n,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       slew_limit
);
    logic                go;
    logic [7:0]          age_q;
    logic [RELOAD_W-1:0] reload_q;
    logic                smp_q;
    logic [1:0]          smp_age_q;

    // Start request on the register port
    assign go = reg_wr && reg_addr == ADDR_CONTROL_TWO && reg_wdata[0];

    // Cycles since request, last reload value
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            age_q    <= 8'hFF;
            reload_q <= '0;
        end
        else
        begin
            if (go)
                age_q <= 8'h00;
            else if (age_q != 8'hFF)
                age_q <= age_q + 8'h01;
            if (reg_wr && reg_addr == ADDR_BAUD_RELOAD)
                reload_q <= reg_wdata[RELOAD_W-1:0];
        end
    end

    // Last slew bit written and its age
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            smp_q     <= 1'b0;
            smp_age_q <= 2'h3;
        end
        else if (reg_wr && reg_addr == ADDR_STATUS)
        begin
            smp_q     <= reg_wdata[7];
            smp_age_q <= 2'h0;
        end
        else if (smp_age_q != 2'h3)
            smp_age_q <= smp_age_q + 2'h1;
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_scl_free;
        scl_oe_n;
    endproperty
    a_scl_free: assert property (p_scl_free)
        else $error("SCL driven");

    property p_sda_zero;
        !$past(rst) |-> sda_out == 1'b0;
    endproperty
    a_sda_zero: assert property (p_sda_zero)
        else $error("SDA driven high");

    property p_rdata_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside read cycle");

    property p_slew;
        smp_age_q >= 2'h2 |-> slew_limit == !smp_q;
    endproperty
    a_slew: assert property (p_slew)
        else $error("slew output wrong");

    property p_drive_cond;
        $fell(sda_oe_n) |-> $past(scl_in) && $past(sda_in);
    endproperty
    a_drive_cond: assert property (p_drive_cond)
        else $error("SDA driven with a line low");

    property p_drive_time;
        $fell(sda_oe_n) |-> int'(age_q) > int'(reload_q)
            && int'(age_q) <= int'(reload_q) + 6;
    endproperty
    a_drive_time: assert property (p_drive_time)
        else $error("first period wrong length");

    property p_drive_holds;
        !sda_oe_n && !go && !$past(go) && !$past(go, 2) |=> !sda_oe_n;
    endproperty
    a_drive_holds: assert property (p_drive_holds)
        else $error("SDA released early");

    property p_collide_quiet;
        go && !scl_in && !sda_in && sda_oe_n |=> sda_oe_n [*8];
    endproperty
    a_collide_quiet: assert property (p_collide_quiet)
        else $error("SDA driven after collision");

    c_drive: cover property ($fell(sda_oe_n));
    c_release: cover property ($rose(sda_oe_n));
    c_collide: cover property (go && !scl_in);
endmodule

bind i2cms_start_gen i2cms_start_chk #(
    .RELOAD_W   (RELOAD_W)
) chk_u (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .reg_addr   (reg_addr),
    .reg_wdata  (reg_wdata),
    .reg_wr     (reg_wr),
    .reg_rd     (reg_rd),
    .reg_rdata  (reg_rdata),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .scl_out    (scl_out),
    .scl_oe_n   (scl_oe_n),
    .sda_out    (sda_out),
    .sda_oe_n   (sda_oe_n),
    .slew_limit (slew_limit)
);

/* File: test/tb_i2cms_start_gen.sv */
`timescale 1ns/1ps
// Register-level bench of the start generator
module tb_i2cms_start_gen
    import i2cms_pkg::*;
();
    logic       clk_sys, rst, reg_wr, reg_rd, hold_scl, hold_sda;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, keep;
    logic       scl_in, sda_in, scl_out, scl_oe_n, sda_out, sda_oe_n;
    logic       slew_limit;
    int         failures, check_count;
    int         nv [2] = '{5, 12};
    logic [7:0] regs [8] = '{ADDR_PERIPH_FLAGS_ONE, ADDR_PERIPH_FLAGS_TWO,
        ADDR_CONTROL_ONE, ADDR_PERIPH_ENABLES_ONE, ADDR_PERIPH_ENABLES_TWO,
        ADDR_CONTROL_TWO, ADDR_BAUD_RELOAD, ADDR_STATUS};

    i2cms_start_gen dut_u (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .scl_in(scl_in), .sda_in(sda_in),
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .slew_limit(slew_limit)
    );

    i2cms_bus_model model_u (
        .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .hold_scl(hold_scl), .hold_sda(hold_sda),
        .scl_in(scl_in), .sda_in(sda_in)
    );

    // 10 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // Read and compare under a mask
    task automatic rc(input logic [7:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        check(v & m, e);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk_sys);
        #1;
    endtask

    // Wait for the SDA enable to reach a level, bounded
    task automatic wait_oe(input logic v);
        int n;
        n = 0;
        #1;
        while (sda_oe_n !== v && n < 200)
        begin
            settle(1);
            n++;
        end
        check({7'h00, sda_oe_n}, {7'h00, v});
    endtask

    // Other bus parties pull lines low
    task automatic lines(input logic s, input logic d);
        @(posedge clk_sys);
        hold_scl <= s;
        hold_sda <= d;
    endtask

    task automatic close_out;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Watchdog against a hung run
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        close_out;
    end

    initial
    begin
        rst = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        hold_scl = 1'b0;
        hold_sda = 1'b0;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        // Reset values and an unmapped address
        foreach (regs[i])
            rc(regs[i], 8'hFF, 8'h00);
        rc(8'h55, 8'hFF, 8'h00);
        // Slew control follows the status bit
        wr(ADDR_STATUS, 8'h80);
        settle(2);
        check({7'h00, slew_limit}, 8'h00);
        rc(ADDR_STATUS, 8'h80, 8'h80);
        wr(ADDR_STATUS, 8'h00);
        // Request while both lines are low
        lines(1'b1, 1'b1);
        wr(ADDR_CONTROL_TWO, 8'h01);
        settle(8);
        check({7'h00, sda_oe_n}, 8'h01);
        lines(1'b0, 1'b0);
        rc(ADDR_PERIPH_FLAGS_TWO, 8'h08, 8'h08);
        rc(ADDR_CONTROL_TWO, 8'hFF, 8'h00);
        wr(ADDR_PERIPH_FLAGS_TWO, 8'h00);
        // Full start, buffer write and ignored request-bit write mid-way
        foreach (nv[k])
        begin
            wr(ADDR_BAUD_RELOAD, 8'(nv[k]));
            rd(ADDR_SHIFT_BUFFER, keep);
            wr(ADDR_CONTROL_TWO, 8'h01);
            wait_oe(1'b1);
            wr(ADDR_SHIFT_BUFFER, 8'hA5);
            wr(ADDR_CONTROL_TWO, 8'h1E);
            wait_oe(1'b0);
            check({6'h00, scl_in, sda_in}, 8'h02);
            check({6'h00, scl_out, scl_oe_n}, 8'h03);
            rc(ADDR_STATUS, 8'h08, 8'h08);
            rc(ADDR_CONTROL_TWO, 8'h1F, 8'h01);
            settle(nv[k] + 8);
            rc(ADDR_CONTROL_TWO, 8'hFF, 8'h00);
            rc(ADDR_PERIPH_FLAGS_ONE, 8'h08, 8'h08);
            rc(ADDR_CONTROL_ONE, 8'h80, 8'h80);
            rc(ADDR_SHIFT_BUFFER, 8'hFF, keep);
            check({7'h00, sda_oe_n}, 8'h00);
            wr(ADDR_PERIPH_FLAGS_ONE, 8'h00);
            wr(ADDR_CONTROL_ONE, 8'h00);
        end
        // Clock pulled low during the first period
        wr(ADDR_BAUD_RELOAD, 8'h14);
        wr(ADDR_CONTROL_TWO, 8'h01);
        wait_oe(1'b1);
        lines(1'b1, 1'b0);
        settle(3);
        lines(1'b0, 1'b0);
        settle(30);
        check({7'h00, sda_oe_n}, 8'h01);
        rc(ADDR_PERIPH_FLAGS_TWO, 8'h08, 8'h08);
        rc(ADDR_CONTROL_TWO, 8'hFF, 8'h00);
        close_out;
    end
endmodule
